// [hdl/twt_power_save_regs.vh]
// Register offsets, fields, reset values and timing constants of the wake-time scheduler
`ifndef TWT_POWER_SAVE_REGS_VH
`define TWT_POWER_SAVE_REGS_VH
`define TWT_A_CTRL 8'h00
`define TWT_A_DUR 8'h04
`define TWT_A_INT 8'h08
`define TWT_A_LAT 8'h0C
`define TWT_A_TPUT 8'h10
`define TWT_A_STAT 8'h14
`define TWT_A_SP 8'h18
`define TWT_A_WI 8'h1C
`define TWT_A_SLP 8'h20
`define TWT_CTRL_EN 0
`define TWT_CTRL_AUTO 1
`define TWT_CTRL_IMPL 2
`define TWT_CTRL_SILENT 3
`define TWT_CTRL_RT_LO 4
`define TWT_CTRL_RT_HI 5
`define TWT_STAT_EVT 0
`define TWT_STAT_REFUSED 1
`define TWT_STAT_ASLEEP 2
`define TWT_STAT_IN_SP 3
`define TWT_STAT_PEND 4
`define TWT_STAT_SCHED 5
`define TWT_CTRL_RST 6'h00
`define TWT_DUR_RST 8'h01
`define TWT_UNIT_RST 8'h01
`define TWT_MANT_RST 16'h0001
`define TWT_EXP_RST 5'h00
`define TWT_LAT_RST 32'h00000000
`define TWT_TPUT_RST 16'h0000
`define TWT_DEV_TPUT_RST 16'h0000
`define TWT_CLK_PERIOD_NS 10
`define TWT_TICK_NS 1000
`define TWT_TICK_CYC (`TWT_TICK_NS / `TWT_CLK_PERIOD_NS)
`define TWT_LAT_MIN_MS 32'h000007D0
`define TWT_AUTO_EXP 5'h0A
`define TWT_AUTO_UNIT 8'h80
`define TWT_AUTO_DUR_HI 8'h40
`define TWT_AUTO_DUR_LO 8'h10
`define TWT_BCN_GUARD 32'h00000010
`endif

// [hdl/twt_power_save.v]
// Target-wake-time power-save scheduler with register port and frame-level link
`timescale 1ns/10ps
`include "twt_power_save_regs.vh"
module twt_power_save #(
	parameter TICK_CYC = `TWT_TICK_CYC,
	parameter [31:0] BCN_GUARD = `TWT_BCN_GUARD
) (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire i_assoc_start,
	input wire i_connected,
	input wire i_rx_resp,
	input wire i_rx_accept,
	input wire i_rx_beacon,
	input wire i_rx_tim_hit,
	input wire i_rx_data,
	input wire i_rx_more_data,
	output reg o_tx_assoc,
	output reg o_tx_twt_req_support,
	output reg o_tx_setup,
	output reg [1:0] o_tx_req_type,
	output reg [31:0] o_tx_sp_len,
	output reg [31:0] o_tx_interval,
	output reg o_tx_implicit,
	output reg o_tx_announced,
	output reg o_tx_null,
	output reg o_tx_trigger,
	output reg o_tx_teardown,
	output reg o_radio_on,
	output reg o_ps_exit,
	output reg o_data_window,
	output reg o_evt_resp
);
	localparam [9:0] S_IDLE = 10'h001;
	localparam [9:0] S_WCONN = 10'h002;
	localparam [9:0] S_SETUP = 10'h004;
	localparam [9:0] S_WACC = 10'h008;
	localparam [9:0] S_NULL = 10'h010;
	localparam [9:0] S_SLEEP = 10'h020;
	localparam [9:0] S_BCN = 10'h040;
	localparam [9:0] S_SLEEP2 = 10'h080;
	localparam [9:0] S_SP = 10'h100;
	localparam [9:0] S_SPEND = 10'h200;
	localparam [31:0] TICK_M1 = TICK_CYC - 1;
	localparam [15:0] TICK_LAST = TICK_M1[15:0];

	// Write decode shared by every writable register
	function wr_hit;
		input we;
		input [7:0] addr;
		input [7:0] offs;
		begin
			wr_hit = we && (addr == offs);
		end
	endfunction

	reg [5:0] ctrl_r;
	reg [7:0] dur_r;
	reg [7:0] unit_r;
	reg [15:0] mant_r;
	reg [4:0] exp_r;
	reg [31:0] lat_r;
	reg [15:0] tput_r;
	reg [15:0] dev_tput_r;
	reg [7:0] eff_dur_r;
	reg [7:0] eff_unit_r;
	reg [15:0] eff_mant_r;
	reg [4:0] eff_exp_r;
	reg [9:0] state_r;
	reg [15:0] div_r;
	reg tick_r;
	reg [31:0] wake_cnt_r;
	reg [31:0] sp_cnt_r;
	reg tim_r;
	reg pend_r;
	reg evt_r;
	reg refused_r;
	reg start_r;
	reg stop_r;
	reg [31:0] rdata_nxt;

	wire wr_ctrl = wr_hit(i_wr, i_addr, `TWT_A_CTRL);
	wire wr_stat = wr_hit(i_wr, i_addr, `TWT_A_STAT);
	wire auto_mode = ctrl_r[`TWT_CTRL_AUTO];
	wire silent = ctrl_r[`TWT_CTRL_SILENT];
	wire [31:0] lat_eff = (lat_r == 32'h0) ? `TWT_LAT_MIN_MS : lat_r;
	wire lat_ok = lat_eff > `TWT_LAT_MIN_MS;
	wire tput_ok = tput_r <= {1'b0, dev_tput_r[15:1]};
	wire auto_ok = lat_ok && tput_ok;
	// Throughput heavy sessions get a longer service period; a coarse split avoids a divider
	wire heavy = {tput_r, 3'b000} > {3'b000, dev_tput_r};
	wire [15:0] sp_prod = eff_dur_r * eff_unit_r;
	wire [31:0] sp_len = {16'h0000, sp_prod};
	wire [31:0] interval = {16'h0000, eff_mant_r} << eff_exp_r;
	wire [31:0] sleep_len = (interval > sp_len) ? (interval - sp_len) : 32'h0;
	wire [31:0] reload = (interval == 32'h0) ? 32'h1 : interval;
	wire sp_start = tick_r && (wake_cnt_r == 32'h1);
	wire sched = (state_r == S_SLEEP) || (state_r == S_BCN) || (state_r == S_SLEEP2)
		|| (state_r == S_SP) || (state_r == S_SPEND);
	wire in_sp = (state_r == S_SP) || (state_r == S_SPEND);
	wire asleep = (state_r == S_SLEEP) || (state_r == S_SLEEP2);

	// Time base: one tick enable per microsecond
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			div_r <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == TICK_LAST);
			if (div_r == TICK_LAST) begin
				div_r <= 16'h0000;
			end else begin
				div_r <= div_r + 16'h0001;
			end
		end
	end

	// Register file and session requests
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_r <= `TWT_CTRL_RST;
			dur_r <= `TWT_DUR_RST;
			unit_r <= `TWT_UNIT_RST;
			mant_r <= `TWT_MANT_RST;
			exp_r <= `TWT_EXP_RST;
			lat_r <= `TWT_LAT_RST;
			tput_r <= `TWT_TPUT_RST;
			dev_tput_r <= `TWT_DEV_TPUT_RST;
			start_r <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			start_r <= wr_ctrl && i_wdata[`TWT_CTRL_EN];
			stop_r <= wr_ctrl && !i_wdata[`TWT_CTRL_EN];
			if (wr_ctrl) begin
				ctrl_r <= i_wdata[5:0];
			end
			if (wr_hit(i_wr, i_addr, `TWT_A_DUR)) begin
				dur_r <= i_wdata[7:0];
				unit_r <= i_wdata[15:8];
			end
			if (wr_hit(i_wr, i_addr, `TWT_A_INT)) begin
				mant_r <= i_wdata[15:0];
				exp_r <= i_wdata[20:16];
			end
			if (wr_hit(i_wr, i_addr, `TWT_A_LAT)) begin
				lat_r <= i_wdata;
			end
			if (wr_hit(i_wr, i_addr, `TWT_A_TPUT)) begin
				tput_r <= i_wdata[15:0];
				dev_tput_r <= i_wdata[31:16];
			end
		end
	end

	always @* begin
		rdata_nxt = 32'h0;
		case (i_addr)
			`TWT_A_CTRL: rdata_nxt = {26'h0, ctrl_r};
			`TWT_A_DUR: rdata_nxt = {16'h0, unit_r, dur_r};
			`TWT_A_INT: rdata_nxt = {11'h0, exp_r, mant_r};
			`TWT_A_LAT: rdata_nxt = lat_r;
			`TWT_A_TPUT: rdata_nxt = {dev_tput_r, tput_r};
			`TWT_A_STAT: rdata_nxt = {26'h0, sched, pend_r, in_sp, asleep, refused_r, evt_r};
			`TWT_A_SP: rdata_nxt = sp_len;
			`TWT_A_WI: rdata_nxt = interval;
			`TWT_A_SLP: rdata_nxt = sleep_len;
			default: rdata_nxt = 32'h0;
		endcase
	end

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= 32'h0;
		end
	end

	// Sticky flags: a hardware set in the clearing cycle wins
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			evt_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			if (i_rx_resp && (state_r == S_WACC)) begin
				evt_r <= 1'b1;
			end else if (wr_stat && i_wdata[`TWT_STAT_EVT]) begin
				evt_r <= 1'b0;
			end
			if (start_r && auto_mode && !auto_ok) begin
				refused_r <= 1'b1;
			end else if (wr_stat && i_wdata[`TWT_STAT_REFUSED]) begin
				refused_r <= 1'b0;
			end
		end
	end

	// Session sequencer and wake schedule
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= S_IDLE;
			eff_dur_r <= `TWT_DUR_RST;
			eff_unit_r <= `TWT_UNIT_RST;
			eff_mant_r <= `TWT_MANT_RST;
			eff_exp_r <= `TWT_EXP_RST;
			wake_cnt_r <= 32'h0;
			sp_cnt_r <= 32'h0;
			tim_r <= 1'b0;
			pend_r <= 1'b0;
			o_tx_assoc <= 1'b0;
			o_tx_twt_req_support <= 1'b0;
			o_tx_setup <= 1'b0;
			o_tx_req_type <= 2'b00;
			o_tx_sp_len <= 32'h0;
			o_tx_interval <= 32'h0;
			o_tx_implicit <= 1'b0;
			o_tx_announced <= 1'b0;
			o_tx_null <= 1'b0;
			o_tx_trigger <= 1'b0;
			o_tx_teardown <= 1'b0;
			o_radio_on <= 1'b1;
			o_ps_exit <= 1'b0;
			o_data_window <= 1'b0;
			o_evt_resp <= 1'b0;
		end else begin
			o_tx_assoc <= i_assoc_start;
			o_tx_twt_req_support <= 1'b1;
			o_tx_setup <= 1'b0;
			o_tx_null <= 1'b0;
			o_tx_trigger <= 1'b0;
			o_tx_teardown <= 1'b0;
			o_evt_resp <= 1'b0;
			if (tick_r && (wake_cnt_r != 32'h0)) begin
				wake_cnt_r <= wake_cnt_r - 32'h1;
			end
			if (sp_start) begin
				wake_cnt_r <= reload;
			end
			if (tick_r && (sp_cnt_r != 32'h0)) begin
				sp_cnt_r <= sp_cnt_r - 32'h1;
			end
			if (stop_r) begin
				if (state_r != S_IDLE) begin
					o_tx_teardown <= 1'b1;
				end
				state_r <= S_IDLE;
				wake_cnt_r <= 32'h0;
				sp_cnt_r <= 32'h0;
				pend_r <= 1'b0;
			end else if (start_r && (state_r == S_IDLE)) begin
				if (!auto_mode) begin
					eff_dur_r <= dur_r;
					eff_unit_r <= unit_r;
					eff_mant_r <= mant_r;
					eff_exp_r <= exp_r;
					state_r <= S_WCONN;
				end else if (auto_ok) begin
					eff_dur_r <= heavy ? `TWT_AUTO_DUR_HI : `TWT_AUTO_DUR_LO;
					eff_unit_r <= `TWT_AUTO_UNIT;
					eff_mant_r <= lat_eff[15:0];
					eff_exp_r <= `TWT_AUTO_EXP;
					state_r <= S_WCONN;
				end
			end else begin
				case (state_r)
					S_IDLE: begin
						state_r <= S_IDLE;
					end
					S_WCONN: begin
						if (i_connected) begin
							state_r <= S_SETUP;
						end
					end
					S_SETUP: begin
						o_tx_setup <= 1'b1;
						o_tx_req_type <= ctrl_r[`TWT_CTRL_RT_HI:`TWT_CTRL_RT_LO];
						o_tx_sp_len <= sp_len;
						o_tx_interval <= interval;
						o_tx_implicit <= ctrl_r[`TWT_CTRL_IMPL];
						o_tx_announced <= !silent;
						state_r <= S_WACC;
					end
					S_WACC: begin
						if (i_rx_resp) begin
							o_evt_resp <= 1'b1;
							state_r <= i_rx_accept ? S_NULL : S_IDLE;
						end
					end
					S_NULL: begin
						o_tx_null <= 1'b1;
						wake_cnt_r <= reload;
						state_r <= S_SLEEP;
					end
					S_SLEEP: begin
						// The retrieval output lags the state, so its last frame lands here
						if (i_rx_data && o_ps_exit) begin
							pend_r <= i_rx_more_data;
						end
						if (sp_start) begin
							state_r <= S_SP;
						end else if (wake_cnt_r <= BCN_GUARD) begin
							state_r <= S_BCN;
						end
					end
					S_BCN: begin
						if (sp_start) begin
							state_r <= S_SP;
						end else if (i_rx_beacon) begin
							tim_r <= i_rx_tim_hit;
							state_r <= S_SLEEP2;
						end
					end
					S_SLEEP2: begin
						if (sp_start) begin
							state_r <= S_SP;
						end
					end
					S_SP: begin
						sp_cnt_r <= sp_len;
						if ((tim_r || pend_r) && !silent) begin
							o_tx_trigger <= 1'b1;
						end
						pend_r <= tim_r || pend_r;
						tim_r <= 1'b0;
						state_r <= S_SPEND;
					end
					S_SPEND: begin
						if (i_rx_data) begin
							pend_r <= i_rx_more_data;
						end
						// Ends on time even with frames left; pend_r carries them over
						if (tick_r && (sp_cnt_r <= 32'h1)) begin
							state_r <= S_SLEEP;
						end
					end
					default: begin
						state_r <= S_IDLE;
					end
				endcase
			end
			o_radio_on <= !asleep && (state_r != S_NULL) || (state_r == S_NULL);
			o_data_window <= in_sp || !sched;
			o_ps_exit <= (state_r == S_SPEND) && pend_r;
		end
	end
endmodule // twt_power_save

// [testbench/twt_monitor.sv]
// Port-level checker for the wake-time scheduler
`timescale 1ns/10ps
module twt_monitor (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire i_assoc_start,
	input wire i_connected,
	input wire i_rx_resp,
	input wire i_rx_accept,
	input wire o_tx_assoc,
	input wire o_tx_twt_req_support,
	input wire o_tx_setup,
	input wire o_tx_null,
	input wire o_tx_trigger,
	input wire o_tx_teardown,
	input wire o_radio_on,
	input wire o_ps_exit,
	input wire o_data_window,
	input wire o_evt_resp
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	assoc_tx_a: assert property (i_assoc_start |=> o_tx_assoc)
		else $error("no association frame");
	req_bit_a: assert property (o_tx_assoc |-> o_tx_twt_req_support)
		else $error("requester bit clear");
	setup_conn_a: assert property (o_tx_setup |-> $past(i_connected))
		else $error("setup while unconnected");
	resp_evt_a: assert property (i_rx_resp |=> o_evt_resp)
		else $error("no host event");
	null_acc_a: assert property (i_rx_resp && i_rx_accept |-> ##[1:2] o_tx_null)
		else $error("no null frame");
	null_sleep_a: assert property (o_tx_null |-> ##[1:3] !o_radio_on)
		else $error("no sleep after null");
	sleep_quiet_a: assert property (!o_radio_on |-> !o_data_window && !o_ps_exit)
		else $error("exchange while asleep");
	exit_win_a: assert property (o_ps_exit |-> o_data_window && o_radio_on)
		else $error("retrieval outside window");
	trig_win_a: assert property (o_tx_trigger |-> o_radio_on && o_data_window)
		else $error("trigger outside window");
	cover property (o_tx_setup);
	cover property (o_ps_exit);
	cover property (o_tx_trigger);
	cover property (o_tx_teardown);
endmodule // twt_monitor

bind twt_power_save twt_monitor mon_u (.i_clk_sys, .i_nrst, .i_assoc_start, .i_connected,
	.i_rx_resp, .i_rx_accept, .o_tx_assoc, .o_tx_twt_req_support, .o_tx_setup, .o_tx_null,
	.o_tx_trigger, .o_tx_teardown, .o_radio_on, .o_ps_exit, .o_data_window, .o_evt_resp);

// [testbench/twt_ap_model.sv]
// Access point model: answers setup, buffers frames, sends beacons and data
`timescale 1ns/10ps
module twt_ap_model (
	input wire i_clk,
	input wire i_nrst,
	input wire i_setup,
	input wire i_radio,
	input wire i_win,
	input wire i_exit,
	input wire i_agree,
	input wire [7:0] i_load,
	input wire i_put,
	output reg o_resp,
	output wire o_acc,
	output reg o_bcn,
	output wire o_tim,
	output reg o_data,
	output wire o_more,
	output reg [7:0] o_cnt
);
	reg rq;
	reg tog;
	reg [2:0] dly;
	// Levels toggle when not qualified so stale values are never trusted
	assign o_acc = o_resp ? i_agree : tog;
	assign o_tim = o_bcn ? (o_cnt != 8'h00) : tog;
	assign o_more = o_data ? (o_cnt > 8'h01) : tog;
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			{rq, tog, dly, o_resp, o_bcn, o_data, o_cnt} <= 16'h0000;
		end else begin
			tog <= ~tog;
			rq <= i_radio;
			o_resp <= (dly == 3'h1);
			dly <= i_setup ? 3'h4 : dly - {2'h0, dly != 3'h0};
			o_bcn <= i_radio && !rq && !i_win;
			o_data <= !o_data && i_exit && o_cnt != 8'h00;
			if (i_put) begin
				o_cnt <= i_load;
			end else if (o_data) begin
				o_cnt <= o_cnt - 8'h01;
			end
		end
	end
endmodule // twt_ap_model

// [testbench/tb_top.sv]
// Self-checking bench for the wake-time scheduler
`timescale 1ns/10ps
`include "twt_power_save_regs.vh"
module tb_top;
	reg clk, nrst, wr, rd, assoc, conn, agree, put;
	reg [7:0] addr;
	reg [31:0] wdata;
	wire [31:0] rdata, spl, itv;
	wire [1:0] rtyp;
	wire [7:0] cnt, sig;
	wire resp, acc, bcn, tim, dat, more, txa, sup, stp, impl, ann, nul, trig, tdn, radio, pex;
	wire win, evt;
	integer errors, compares, cyc, i, n;
	time tq[$];
	logic [31:0] rows [3][6] = '{'{32'h01, 32'h0204, 32'h10040, 32'h08, 32'h80, 32'h78},
		'{32'h15, 32'h0305, 32'h20010, 32'h0F, 32'h40, 32'h31},
		'{32'h29, 32'h010A, 32'h00050, 32'h0A, 32'h50, 32'h46}};
	assign sig = {tdn, evt, nul, stp, pex, txa, ~pex, cnt == 8'h00};
	twt_power_save #(.TICK_CYC(1)) dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_assoc_start(assoc),
		.i_connected(conn), .i_rx_resp(resp), .i_rx_accept(acc), .i_rx_beacon(bcn),
		.i_rx_tim_hit(tim), .i_rx_data(dat), .i_rx_more_data(more), .o_tx_assoc(txa),
		.o_tx_twt_req_support(sup), .o_tx_setup(stp), .o_tx_req_type(rtyp),
		.o_tx_sp_len(spl), .o_tx_interval(itv), .o_tx_implicit(impl), .o_tx_announced(ann),
		.o_tx_null(nul), .o_tx_trigger(trig), .o_tx_teardown(tdn), .o_radio_on(radio),
		.o_ps_exit(pex), .o_data_window(win), .o_evt_resp(evt));
	twt_ap_model ap_u (.i_clk(clk), .i_nrst(nrst), .i_setup(stp), .i_radio(radio),
		.i_win(win), .i_exit(pex), .i_agree(agree), .i_load(8'h14), .i_put(put),
		.o_resp(resp), .o_acc(acc), .o_bcn(bcn), .o_tim(tim), .o_data(dat), .o_more(more),
		.o_cnt(cnt));
	task chk(input string nm, input [31:0] s, input [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask
	task wrt(input [7:0] a, input [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdr(input [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
	endtask
	// Bounded wait on one of the watched outputs
	task wt(input integer k);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (!sig[k] && n < 3000);
		chk("wait", {31'h0, sig[k]}, 32'h1);
	endtask
	task summarize;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (trig)
			tq.push_back($time);
		if (cyc == 20000) begin
			errors++;
			summarize;
		end
	end
	initial begin
		{nrst, wr, rd, assoc, conn, agree, put, addr, wdata} = 47'h0;
		{errors, compares, cyc} = 0;
		repeat (4) @(posedge clk);
		chk("radio_rst", {31'h0, radio}, 32'h1);
		nrst <= 1'b1;
		rdr(8'hFC);
		chk("unmapped", rdata, 32'h0);
		assoc <= 1'b1;
		wt(2);
		assoc <= 1'b0;
		chk("req_bit", {31'h0, sup}, 32'h1);
		conn <= 1'b1;
		// Rejected sessions: parameters on the air and derived times
		for (i = 0; i < 3; i++) begin
			wrt(`TWT_A_DUR, rows[i][1]);
			wrt(`TWT_A_INT, rows[i][2]);
			wrt(`TWT_A_CTRL, rows[i][0]);
			wt(4);
			chk("sp", spl, rows[i][3]);
			chk("wi", itv, rows[i][4]);
			chk("type", {30'h0, rtyp}, {30'h0, rows[i][0][5:4]});
			chk("impl", {31'h0, impl}, {31'h0, rows[i][0][2]});
			chk("ann", {31'h0, ann}, {31'h0, !rows[i][0][3]});
			wt(6);
			rdr(`TWT_A_SLP);
			chk("slp", rdata, rows[i][5]);
			wrt(`TWT_A_CTRL, 32'h0);
		end
		// Automatic mode latency and throughput limits, then accepted session and teardown
		agree <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wrt(`TWT_A_STAT, 32'h3);
			wrt(`TWT_A_LAT, i * 2000 + (i / 2));
			wrt(`TWT_A_TPUT, (i == 2) ? 32'h00100009 : 32'h0);
			wrt(`TWT_A_CTRL, 32'h3);
			rdr(`TWT_A_STAT);
			chk("refused", {31'h0, rdata[1]}, {31'h0, i < 3});
		end
		wt(4);
		chk("auto_sp", spl, 32'h800);
		chk("auto_wi", itv, 32'd6001 * 32'h400);
		wt(5);
		wrt(`TWT_A_CTRL, 32'h2);
		wt(7);
		// Buffered traffic spanning several periods
		wrt(`TWT_A_DUR, 32'h0204);
		wrt(`TWT_A_INT, 32'h10040);
		put <= 1'b1;
		wrt(`TWT_A_CTRL, 32'h5);
		put <= 1'b0;
		wt(5);
		wt(3);
		wt(1);
		chk("left", {31'h0, cnt != 8'h00}, 32'h1);
		rdr(`TWT_A_STAT);
		chk("pend", {31'h0, rdata[4]}, 32'h1);
		wt(0);
		wt(1);
		rdr(`TWT_A_STAT);
		chk("drained", {31'h0, rdata[4]}, 32'h0);
		chk("period", (tq[1] - tq[0]) / 10, 32'h80);
		wrt(`TWT_A_CTRL, 32'h0);
		summarize;
	end
endmodule // tb_top
